// [mcd_core.v]
`timescale 1ns/1ps
`include "mcd_consts.vh"
module mcd_core
(
    input wire core_clk_i,
    input wire rst_n_i,
    input wire mem_sel_i,
    input wire mem_we_i,
    input wire [2:0] mem_addr_i,
    input wire [15:0] mem_wdata_i,
    output reg [15:0] mem_rdata_o,
    input wire l1_clk_i,
    input wire l1_fsync_i,
    input wire l1_rxd_i,
    output reg l1_txd_o,
    output reg chan1_irq_o,
    output reg chan2_irq_o,
    output reg frame_lost_o
);
    // ****************************************************************
    // Link input synchronisers and edge detection.
    // ****************************************************************
    reg [2:0] clk_s_q;
    reg [1:0] fs_s_q;
    reg [1:0] rxd_s_q;
    wire l1_rise;
    wire l1_fall;
    wire rx_bit;
    reg [4:0] bit_cnt_q;
    reg [17:0] rx_sh_q;
    reg [17:0] tx_sh_q;
    reg frame_done_q;
    // Descriptor words, mode byte and transmit shadow.
    reg [15:0] rx1_q;
    reg [15:0] tx1_q;
    reg [15:0] rx2_q;
    reg [15:0] tx2_q;
    reg [7:0] mode_q;
    reg [7:0] sh1_q;
    reg sh_a_q;
    reg sh_e_q;
    reg [7:0] sh2_q;
    // Monitor protocol and command channel state.
    reg [7:0] prev_q;
    reg prev_ok_q;
    reg got_q;
    reg pend_q;
    reg wait_q;
    reg [3:0] ci_prev_q;
    reg [3:0] ci_acc_q;
    reg rx1_own_q;
    reg tx1_own_q;
    reg rx2_own_q;
    reg tx2_own_q;
    reg host_wr_q;
    // Two-entry frame buffer.
    reg [17:0] buf0_q;
    reg [17:0] buf1_q;
    reg wr_ptr_q;
    reg rd_ptr_q;
    reg [1:0] count_q;
    wire in_ready;
    wire push;
    wire out_valid;
    wire out_ready;
    wire pop;
    wire [17:0] head;
    wire [7:0] d1;
    wire [7:0] d2;
    wire a_rx;
    wire e_rx;
    wire [3:0] ci;
    wire [2:0] mode;
    wire en1;
    wire en2;
    wire proto;
    wire transp;
    wire link;

    assign l1_rise = clk_s_q[1] & ~clk_s_q[2];
    assign l1_fall = ~clk_s_q[1] & clk_s_q[2];
    // Loopback feeds our own transmitted bit back to the receiver.
    assign rx_bit = mode_q[`MCD_M_LOOP] ? l1_txd_o : rxd_s_q[1];

    always @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            clk_s_q <= 3'h0;
            fs_s_q <= 2'h0;
            rxd_s_q <= 2'h0;
        end
        else
        begin
            clk_s_q <= {clk_s_q[1:0], l1_clk_i};
            fs_s_q <= {fs_s_q[0], l1_fsync_i};
            rxd_s_q <= {rxd_s_q[0], l1_rxd_i};
        end
    end

    // ****************************************************************
    // Frame shifter: bits sampled on rising link edges, sent on falling.
    // ****************************************************************
    always @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            bit_cnt_q <= 5'h0;
            rx_sh_q <= 18'h0;
            tx_sh_q <= 18'h0;
            frame_done_q <= 1'b0;
            l1_txd_o <= 1'b1;
        end
        else
        begin
            frame_done_q <= 1'b0;
            if (l1_rise && fs_s_q[1])
            begin
                bit_cnt_q <= 5'h1;
                rx_sh_q <= {17'h0, rx_bit};
                tx_sh_q <= {sh1_q, sh2_q, sh_a_q, sh_e_q};
            end
            else if (l1_rise && bit_cnt_q != 5'h0)
            begin
                rx_sh_q <= {rx_sh_q[16:0], rx_bit};
                if (bit_cnt_q == `MCD_FRAME_LAST - 5'h1)
                begin
                    bit_cnt_q <= 5'h0;
                    frame_done_q <= 1'b1;
                end
                else
                begin
                    bit_cnt_q <= bit_cnt_q + 5'h1;
                end
            end
            if (l1_fall)
            begin
                l1_txd_o <= tx_sh_q[`MCD_FRAME_BITS - 1];
                tx_sh_q <= {tx_sh_q[16:0], 1'b1};
            end
        end
    end

    // ****************************************************************
    // Frame buffer.
    // ****************************************************************
    // A frame that finds the buffer full is dropped and reported, since
    // the line itself cannot be held off.
    assign in_ready = (count_q != 2'h2);
    assign push = frame_done_q & in_ready;
    assign out_valid = (count_q != 2'h0);
    assign out_ready = ~mem_sel_i;
    assign pop = out_valid & out_ready;
    assign head = rd_ptr_q ? buf1_q : buf0_q;

    always @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            buf0_q <= 18'h0;
            buf1_q <= 18'h0;
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q <= 2'h0;
            frame_lost_o <= 1'b0;
        end
        else
        begin
            frame_lost_o <= frame_done_q & ~in_ready;
            if (push && !wr_ptr_q)
                buf0_q <= rx_sh_q;
            if (push && wr_ptr_q)
                buf1_q <= rx_sh_q;
            if (push)
                wr_ptr_q <= ~wr_ptr_q;
            if (pop)
                rd_ptr_q <= ~rd_ptr_q;
            if (push && !pop)
                count_q <= count_q + 2'h1;
            else if (pop && !push)
                count_q <= count_q - 2'h1;
        end
    end

    // ****************************************************************
    // Descriptor engine.
    // ****************************************************************
    assign d1 = head[`MCD_F_D1_HI:`MCD_F_D1_LO];
    assign d2 = head[`MCD_F_D2_HI:`MCD_F_D2_LO];
    assign a_rx = head[`MCD_F_A];
    assign e_rx = head[`MCD_F_E];
    assign ci = d2[`MCD_CI_HI:`MCD_CI_LO];
    assign mode = mode_q[`MCD_M_MODE_HI:`MCD_M_MODE_LO];
    assign en1 = mode_q[`MCD_M_EN1];
    assign en2 = mode_q[`MCD_M_EN2];
    assign link = mode[2];
    assign proto = ~mode[2] & mode[1];
    assign transp = (mode == `MCD_MODE_TRANSP);

    always @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            rx1_q <= `MCD_RESET_WORD;
            tx1_q <= `MCD_RESET_WORD;
            rx2_q <= `MCD_RESET_WORD;
            tx2_q <= `MCD_RESET_WORD;
            mode_q <= 8'h00;
            mem_rdata_o <= 16'h0000;
            sh1_q <= `MCD_IDLE_BYTE;
            sh2_q <= `MCD_IDLE_BYTE;
            sh_a_q <= 1'b0;
            sh_e_q <= 1'b0;
            prev_q <= 8'h00;
            prev_ok_q <= 1'b0;
            got_q <= 1'b0;
            pend_q <= 1'b0;
            wait_q <= 1'b0;
            ci_prev_q <= 4'h0;
            ci_acc_q <= 4'h0;
        end
        else if (mem_sel_i)
        begin
            // Host access owns the memory this cycle; frames wait.
            if (mem_we_i)
            begin
                case (mem_addr_i)
                    `MCD_IDX_RX1: rx1_q <= mem_wdata_i;
                    `MCD_IDX_TX1: tx1_q <= mem_wdata_i;
                    `MCD_IDX_RX2: rx2_q <= mem_wdata_i;
                    `MCD_IDX_TX2: tx2_q <= mem_wdata_i;
                    `MCD_IDX_MODE: mode_q <= mem_wdata_i[7:0];
                    default: mode_q <= mode_q;
                endcase
            end
            case (mem_addr_i)
                `MCD_IDX_RX1: mem_rdata_o <= rx1_q;
                `MCD_IDX_TX1: mem_rdata_o <= tx1_q;
                `MCD_IDX_RX2: mem_rdata_o <= rx2_q;
                `MCD_IDX_TX2: mem_rdata_o <= tx2_q;
                `MCD_IDX_MODE: mem_rdata_o <= {8'h00, mode_q};
                default: mem_rdata_o <= 16'h0000;
            endcase
        end
        else if (pop)
        begin
            // Channel one receive.
            if (en1 && (link || transp))
            begin
                if (rx1_q[`MCD_B_OWN] && (transp || mode_q[`MCD_M_HUNT1_N] ||
                    d1 != `MCD_IDLE_BYTE))
                begin
                    rx1_q[`MCD_DATA_HI:0] <= d1;
                    rx1_q[`MCD_B_ABIT] <= transp & a_rx;
                    rx1_q[`MCD_B_EBIT] <= transp & e_rx;
                    rx1_q[`MCD_B_OWN] <= 1'b0;
                end
            end
            else if (en1 && proto)
            begin
                if (e_rx)
                begin
                    prev_q <= d1;
                    prev_ok_q <= 1'b1;
                    rx1_q[`MCD_B_MISM] <= prev_ok_q & (d1 != prev_q);
                    if (prev_ok_q && d1 == prev_q && !got_q && !pend_q &&
                        rx1_q[`MCD_B_OWN])
                    begin
                        rx1_q[`MCD_DATA_HI:0] <= d1;
                        rx1_q[`MCD_B_LAST] <= 1'b0;
                        rx1_q[`MCD_B_ERR] <= 1'b0;
                        rx1_q[`MCD_B_OWN] <= 1'b0;
                        got_q <= 1'b1;
                        pend_q <= 1'b1;
                    end
                    else if (d1 != prev_q)
                    begin
                        got_q <= 1'b0;
                        if (pend_q && rx1_q[`MCD_B_OWN])
                        begin
                            rx1_q[`MCD_B_LAST] <= 1'b1;
                            rx1_q[`MCD_B_ERR] <= 1'b1;
                            rx1_q[`MCD_B_OWN] <= 1'b0;
                            pend_q <= 1'b0;
                        end
                    end
                end
                else if (prev_ok_q && rx1_q[`MCD_B_OWN])
                begin
                    rx1_q[`MCD_B_LAST] <= 1'b1;
                    rx1_q[`MCD_B_ERR] <= 1'b0;
                    rx1_q[`MCD_B_OWN] <= 1'b0;
                    prev_ok_q <= 1'b0;
                    got_q <= 1'b0;
                    pend_q <= 1'b0;
                end
                // The acknowledge goes out for one frame once the host frees the slot.
                sh_a_q <= pend_q & rx1_q[`MCD_B_OWN];
                if (pend_q && rx1_q[`MCD_B_OWN])
                    pend_q <= 1'b0;
            end
            // Channel one transmit.
            if (en1 && (link || transp) && tx1_q[`MCD_B_OWN])
            begin
                sh1_q <= tx1_q[`MCD_DATA_HI:0];
                sh_a_q <= transp & tx1_q[`MCD_B_ABIT];
                sh_e_q <= transp & tx1_q[`MCD_B_EBIT];
                tx1_q[`MCD_B_OWN] <= 1'b0;
            end
            else if (en1 && proto)
            begin
                if (wait_q && a_rx)
                begin
                    tx1_q[`MCD_B_OWN] <= 1'b0;
                    wait_q <= 1'b0;
                    if (tx1_q[`MCD_B_LAST])
                        sh_e_q <= 1'b0;
                end
                else if (!wait_q && a_rx && sh_e_q)
                begin
                    tx1_q[`MCD_B_ABORT] <= 1'b1;
                    sh_e_q <= 1'b0;
                end
                else if (!wait_q && tx1_q[`MCD_B_OWN])
                begin
                    sh1_q <= tx1_q[`MCD_DATA_HI:0];
                    sh_e_q <= 1'b1;
                    wait_q <= 1'b1;
                end
            end
            // Channel two.
            if (en2 && link)
            begin
                if (rx2_q[`MCD_B_OWN] && (mode_q[`MCD_M_HUNT2_N] ||
                    d2 != `MCD_IDLE_BYTE))
                begin
                    rx2_q[`MCD_DATA_HI:0] <= d2;
                    rx2_q[`MCD_B_OWN] <= 1'b0;
                end
                if (tx2_q[`MCD_B_OWN])
                begin
                    sh2_q <= tx2_q[`MCD_DATA_HI:0];
                    tx2_q[`MCD_B_OWN] <= 1'b0;
                end
            end
            else if (en2)
            begin
                ci_prev_q <= ci;
                if (ci == ci_prev_q && ci != ci_acc_q)
                begin
                    ci_acc_q <= ci;
                    if (rx2_q[`MCD_B_OWN])
                    begin
                        rx2_q[`MCD_CI_HI:`MCD_CI_LO] <= ci;
                        rx2_q[1:0] <= 2'h0;
                        rx2_q[`MCD_B_OWN] <= 1'b0;
                    end
                end
                if (tx2_q[`MCD_B_OWN])
                begin
                    sh2_q <= {2'h0, tx2_q[`MCD_CI_HI:`MCD_CI_LO], 2'h0};
                    tx2_q[`MCD_B_OWN] <= 1'b0;
                end
            end
        end
    end

    // ****************************************************************
    // Per-channel interrupt pulses on device hand-back of a descriptor.
    // ****************************************************************
    always @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            rx1_own_q <= 1'b0;
            tx1_own_q <= 1'b0;
            rx2_own_q <= 1'b0;
            tx2_own_q <= 1'b0;
            host_wr_q <= 1'b0;
            chan1_irq_o <= 1'b0;
            chan2_irq_o <= 1'b0;
        end
        else
        begin
            rx1_own_q <= rx1_q[`MCD_B_OWN];
            tx1_own_q <= tx1_q[`MCD_B_OWN];
            rx2_own_q <= rx2_q[`MCD_B_OWN];
            tx2_own_q <= tx2_q[`MCD_B_OWN];
            host_wr_q <= mem_sel_i & mem_we_i;
            // A host write that clears an own bit is not a hand-back.
            chan1_irq_o <= en1 & ~host_wr_q & ((rx1_own_q & ~rx1_q[`MCD_B_OWN]) |
                (tx1_own_q & ~tx1_q[`MCD_B_OWN]));
            chan2_irq_o <= en2 & ~host_wr_q & ((rx2_own_q & ~rx2_q[`MCD_B_OWN]) |
                (tx2_own_q & ~tx2_q[`MCD_B_OWN]));
        end
    end
endmodule // mcd_core

// [mcd_consts.vh]
`ifndef MCD_CONSTS_VH
`define MCD_CONSTS_VH
// ****************************************************************
// Shared memory word indices.
// ****************************************************************
`define MCD_IDX_RX1 3'h0
`define MCD_IDX_TX1 3'h1
`define MCD_IDX_RX2 3'h2
`define MCD_IDX_TX2 3'h3
`define MCD_IDX_MODE 3'h4
// ****************************************************************
// Descriptor fields.
// ****************************************************************
`define MCD_B_OWN 15
`define MCD_B_LAST 14
`define MCD_B_ERR 13
`define MCD_B_ABORT 13
`define MCD_B_MISM 12
`define MCD_B_ABIT 9
`define MCD_B_EBIT 8
`define MCD_DATA_HI 7
`define MCD_CI_HI 5
`define MCD_CI_LO 2
`define MCD_RESET_WORD 16'h0000
`define MCD_IDLE_BYTE 8'hFF
// ****************************************************************
// Mode byte fields and codes.
// ****************************************************************
`define MCD_M_EN1 0
`define MCD_M_EN2 1
`define MCD_M_LOOP 2
`define MCD_M_MODE_HI 5
`define MCD_M_MODE_LO 3
`define MCD_MODE_OFF 3'h0
`define MCD_MODE_TRANSP 3'h1
`define MCD_M_LINK 5
`define MCD_M_PROTO 4
`define MCD_M_HUNT1_N 4
`define MCD_M_HUNT2_N 3
// ****************************************************************
// Serial frame: monitor byte, second byte, A bit, E bit.
// ****************************************************************
`define MCD_FRAME_BITS 18
`define MCD_FRAME_LAST 5'h12
`define MCD_F_D1_HI 17
`define MCD_F_D1_LO 10
`define MCD_F_D2_HI 9
`define MCD_F_D2_LO 2
`define MCD_F_A 1
`define MCD_F_E 0
`endif

// [mcd_core_sva.sv]
`timescale 1ns/1ps
// ****************************************************************
// Port checker
// ****************************************************************
module mcd_core_sva
(
    input wire core_clk_i,
    input wire rst_n_i,
    input wire mem_sel_i,
    input wire mem_we_i,
    input wire [2:0] mem_addr_i,
    input wire [15:0] mem_wdata_i,
    input wire [15:0] mem_rdata_o,
    input wire l1_clk_i,
    input wire l1_fsync_i,
    input wire l1_rxd_i,
    input wire l1_txd_o,
    input wire chan1_irq_o,
    input wire chan2_irq_o,
    input wire frame_lost_o
);
    reg [7:0] mode_q;
    reg lclk_q;
    reg [3:0] fall_q;
    reg [8:0] sync_q;
    // Only the host writes the mode byte, so this shadow is exact.
    always @(posedge core_clk_i)
    begin
        lclk_q <= l1_clk_i;
        if (!rst_n_i)
        begin
            mode_q <= 8'h00;
            fall_q <= 4'hF;
            sync_q <= 9'h1FF;
        end
        else
        begin
            if (mem_sel_i && mem_we_i && mem_addr_i == 3'h4)
                mode_q <= mem_wdata_i[7:0];
            if (lclk_q && !l1_clk_i)
                fall_q <= 4'h0;
            else if (fall_q != 4'hF)
                fall_q <= fall_q + 4'h1;
            if (l1_fsync_i)
                sync_q <= 9'h000;
            else if (sync_q != 9'h1FF)
                sync_q <= sync_q + 9'h001;
        end
    end
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    irq1_enable_a: assert property (chan1_irq_o |-> mode_q[0])
        else $error("channel one interrupt while disabled");
    irq2_enable_a: assert property (chan2_irq_o |-> mode_q[1])
        else $error("channel two interrupt while disabled");
    irq1_pulse_a: assert property (chan1_irq_o |=> !chan1_irq_o)
        else $error("channel one interrupt longer than a pulse");
    irq2_pulse_a: assert property (chan2_irq_o |=> !chan2_irq_o)
        else $error("channel two interrupt longer than a pulse");
    irq_cause_a: assert property ((chan1_irq_o || chan2_irq_o) |-> sync_q < 9'h12C)
        else $error("interrupt with no recent frame");
    mode_read_a: assert property ((mem_sel_i && !mem_we_i && mem_addr_i == 3'h4)
        |=> mem_rdata_o == {8'h00, $past(mode_q)})
        else $error("mode byte read back wrong");
    host_atomic_a: assert property ((mem_sel_i && mem_we_i && mem_addr_i < 3'h4)
        ##1 (mem_sel_i && !mem_we_i && $stable(mem_addr_i))
        |=> mem_rdata_o == $past(mem_wdata_i, 2))
        else $error("descriptor changed under host access");
    tx_timing_a: assert property ($changed(l1_txd_o) |-> fall_q != 4'hF)
        else $error("serial output moved away from link edges");
    lost_pulse_a: assert property (frame_lost_o |=> !frame_lost_o)
        else $error("frame loss flag longer than a pulse");
    cover property (chan1_irq_o);
    cover property (chan2_irq_o);
    cover property (frame_lost_o);
endmodule // mcd_core_sva

bind mcd_core mcd_core_sva i_mcd_core_sva
(
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .mem_sel_i(mem_sel_i),
    .mem_we_i(mem_we_i),
    .mem_addr_i(mem_addr_i),
    .mem_wdata_i(mem_wdata_i),
    .mem_rdata_o(mem_rdata_o),
    .l1_clk_i(l1_clk_i),
    .l1_fsync_i(l1_fsync_i),
    .l1_rxd_i(l1_rxd_i),
    .l1_txd_o(l1_txd_o),
    .chan1_irq_o(chan1_irq_o),
    .chan2_irq_o(chan2_irq_o),
    .frame_lost_o(frame_lost_o)
);

// [mcd_l1_model.sv]
`timescale 1ns/1ps
// ****************************************************************
// Layer-1 transceiver model
// ****************************************************************
module mcd_l1_model
(
    input wire l1_txd_i,
    output reg l1_clk_o,
    output reg l1_fsync_o,
    output reg l1_rxd_o
);
    initial
    begin
        l1_clk_o = 1'b0;
        l1_fsync_o = 1'b0;
        l1_rxd_o = 1'b1;
    end
    // The clock stands low between frames; the data line then shows the inverse
    // of its last bit, so a stale level is never taken for data.
    task send_frame(input [17:0] rxf, output [17:0] txf);
        integer k;
        begin
            txf = 18'h00000;
            for (k = 17; k >= 0; k = k - 1)
            begin
                l1_rxd_o = rxf[k];
                l1_fsync_o = (k == 17);
                #200;
                l1_clk_o = 1'b1;
                #100;
                if (k != 17)
                    txf = {txf[16:0], l1_txd_i};
                #100;
                l1_clk_o = 1'b0;
            end
            l1_fsync_o = 1'b0;
            l1_rxd_o = ~rxf[0];
            #300;
            txf = {txf[16:0], l1_txd_i};
        end
    endtask
endmodule // mcd_l1_model

// [tb_top.sv]
`timescale 1ns/1ps
// ****************************************************************
// Self-checking bench
// ****************************************************************
module tb_top;
    reg core_clk_i;
    reg rst_n_i;
    reg mem_sel_i;
    reg mem_we_i;
    reg [2:0] mem_addr_i;
    reg [15:0] mem_wdata_i;
    wire [15:0] rdata;
    wire lclk;
    wire fsync;
    wire rxd;
    wire txd;
    wire irq1;
    wire irq2;
    wire lost;
    integer n_fail;
    integer num_checks;
    integer n_irq1;
    integer n_irq2;
    integer n_lost;
    integer b1;
    integer m;
    reg [17:0] txf;
    reg [15:0] rd;
    mcd_core i_mcd_core
    (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .mem_sel_i(mem_sel_i),
        .mem_we_i(mem_we_i), .mem_addr_i(mem_addr_i), .mem_wdata_i(mem_wdata_i),
        .mem_rdata_o(rdata), .l1_clk_i(lclk), .l1_fsync_i(fsync), .l1_rxd_i(rxd),
        .l1_txd_o(txd), .chan1_irq_o(irq1), .chan2_irq_o(irq2), .frame_lost_o(lost)
    );
    mcd_l1_model i_mcd_l1_model
    (
        .l1_txd_i(txd), .l1_clk_o(lclk), .l1_fsync_o(fsync), .l1_rxd_o(rxd)
    );
    initial
    begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = ~core_clk_i;
    end
    // Counting waits for reset, since the pulses are unknown before the first edge.
    always @(posedge core_clk_i)
    begin
        if (rst_n_i)
        begin
            n_irq1 <= n_irq1 + irq1;
            n_irq2 <= n_irq2 + irq2;
            n_lost <= n_lost + lost;
        end
    end
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", num_checks, n_fail);
            if (n_fail == 0 && num_checks > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    task check(input [31:0] g, input [31:0] e);
        begin
            num_checks = num_checks + 1;
            if (g !== e)
            begin
                n_fail = n_fail + 1;
                $display("BAD %0t got %h expected %h", $time, g, e);
            end
        end
    endtask
    // Host tasks leave the select high; frame() releases it so queued frames can drain.
    task wr(input [2:0] a, input [15:0] d);
        begin
            @(negedge core_clk_i);
            mem_sel_i = 1'b1;
            mem_we_i = 1'b1;
            mem_addr_i = a;
            mem_wdata_i = d;
        end
    endtask
    task rd_word(input [2:0] a);
        begin
            @(negedge core_clk_i);
            mem_sel_i = 1'b1;
            mem_we_i = 1'b0;
            mem_addr_i = a;
            @(negedge core_clk_i);
            rd = rdata;
        end
    endtask
    task chk(input [2:0] a, input [15:0] e);
        begin
            rd_word(a);
            check(rd, e);
        end
    endtask
    task frame(input [7:0] d1, input [7:0] d2, input a, input e);
        begin
            @(negedge core_clk_i);
            mem_sel_i = 1'b0;
            #13;
            i_mcd_l1_model.send_frame({d1, d2, a, e}, txf);
            repeat (30) @(negedge core_clk_i);
        end
    endtask
    task t_reset;
        begin
            for (m = 0; m < 8; m = m + 1)
                chk(m[2:0], 16'h0000);
            wr(3'h6, 16'hFFFF);
            chk(3'h6, 16'h0000);
            check(txd, 1'b1);
        end
    endtask
    task t_transp;
        begin
            wr(3'h4, 16'h000B);
            wr(3'h0, 16'h8000);
            wr(3'h1, 16'h825A);
            chk(3'h1, 16'h825A);
            b1 = n_irq1;
            // The shadow is loaded after a frame, so a new byte leaves in the next one.
            frame(8'hC3, 8'h00, 1'b1, 1'b0);
            check(txf, {8'hFF, 8'hFF, 2'b00});
            chk(3'h0, 16'h02C3);
            chk(3'h1, 16'h025A);
            check(n_irq1 - b1, 1);
            frame(8'h11, 8'h00, 1'b0, 1'b1);
            check(txf, {8'h5A, 8'hFF, 2'b10});
            chk(3'h0, 16'h02C3);
            chk(3'h4, 16'h000B);
        end
    endtask
    task t_off;
        begin
            wr(3'h4, 16'h0008);
            wr(3'h0, 16'h8000);
            wr(3'h1, 16'h8155);
            b1 = n_irq1;
            frame(8'h3C, 8'h00, 1'b0, 1'b0);
            chk(3'h0, 16'h8000);
            chk(3'h1, 16'h8155);
            check(n_irq1 - b1, 0);
            check(txf, {8'h5A, 8'hFF, 2'b10});
        end
    endtask
    task t_cmd;
        begin
            wr(3'h4, 16'h0003);
            wr(3'h0, 16'h8000);
            wr(3'h2, 16'h8000);
            wr(3'h3, 16'h8014);
            frame(8'h42, 8'h27, 1'b0, 1'b1);
            chk(3'h2, 16'h8000);
            chk(3'h0, 16'h8000);
            frame(8'h42, 8'h27, 1'b0, 1'b1);
            check(txf[9:2], 8'h14);
            chk(3'h2, 16'h0024);
            frame(8'h42, 8'h18, 1'b0, 1'b1);
            frame(8'h42, 8'h18, 1'b0, 1'b1);
            chk(3'h2, 16'h0024);
        end
    endtask
    task t_link;
        begin
            for (m = 4; m < 8; m = m + 1)
            begin
                wr(3'h4, {10'h000, m[2:0], 3'h3});
                wr(3'h0, 16'h8000);
                wr(3'h2, 16'h8000);
                frame(8'hFF, 8'hFF, 1'b1, 1'b1);
                chk(3'h0, (m == 4 || m == 5) ? 16'h8000 : 16'h00FF);
                chk(3'h2, (m == 4 || m == 6) ? 16'h8000 : 16'h00FF);
            end
            wr(3'h3, 16'h803C);
            wr(3'h2, 16'h8000);
            b1 = n_irq2;
            frame(8'h12, 8'h34, 1'b1, 1'b1);
            chk(3'h2, 16'h0034);
            chk(3'h3, 16'h003C);
            check(n_irq2 - b1, 1);
            frame(8'h00, 8'h00, 1'b0, 1'b0);
            check(txf[9:2], 8'h3C);
        end
    endtask
    // The host holds the memory for three frames, so the two-entry buffer overflows.
    task t_buffer;
        begin
            wr(3'h0, 16'h8000);
            rd_word(3'h4);
            b1 = n_lost;
            i_mcd_l1_model.send_frame({8'h21, 8'h00, 2'b11}, txf);
            i_mcd_l1_model.send_frame({8'h22, 8'h00, 2'b11}, txf);
            i_mcd_l1_model.send_frame({8'h23, 8'h00, 2'b11}, txf);
            repeat (10) @(negedge core_clk_i);
            check(n_lost - b1, 1);
            frame(8'h00, 8'h00, 1'b1, 1'b1);
            chk(3'h0, 16'h0021);
        end
    endtask
    task t_monitor;
        begin
            wr(3'h4, 16'h0013);
            wr(3'h0, 16'h8000);
            wr(3'h1, 16'h0000);
            frame(8'h66, 8'h00, 1'b0, 1'b1);
            frame(8'h77, 8'h00, 1'b0, 1'b1);
            rd_word(3'h0);
            check(rd, 16'h9000);
            b1 = n_irq1;
            frame(8'h77, 8'h00, 1'b0, 1'b1);
            chk(3'h0, 16'h0077);
            check(n_irq1 - b1, 1);
            frame(8'h77, 8'h00, 1'b0, 1'b1);
            check(txf[1], 1'b0);
            wr(3'h0, 16'h8000);
            frame(8'h00, 8'h00, 1'b0, 1'b0);
            rd_word(3'h0);
            check(rd[15:13], 3'h2);
            wr(3'h1, 16'hC0A5);
            // The acknowledge and the new byte each leave one frame after they are decided.
            frame(8'h00, 8'h00, 1'b0, 1'b0);
            check(txf[1], 1'b1);
            chk(3'h1, 16'hC0A5);
            frame(8'h00, 8'h00, 1'b1, 1'b0);
            check({txf[17:10], txf[0]}, {8'hA5, 1'b1});
            chk(3'h1, 16'h40A5);
            frame(8'h00, 8'h00, 1'b0, 1'b0);
            check(txf[0], 1'b0);
            wr(3'h1, 16'h8011);
            frame(8'h00, 8'h00, 1'b0, 1'b0);
            frame(8'h00, 8'h00, 1'b1, 1'b0);
            frame(8'h00, 8'h00, 1'b1, 1'b0);
            chk(3'h1, 16'h2011);
        end
    endtask
    initial
    begin
        #1000000;
        n_fail = n_fail + 1;
        tally_and_finish;
    end
    initial
    begin
        n_fail = 0;
        num_checks = 0;
        n_irq1 = 0;
        n_irq2 = 0;
        n_lost = 0;
        rst_n_i = 1'b0;
        mem_sel_i = 1'b0;
        mem_we_i = 1'b0;
        mem_addr_i = 3'h0;
        mem_wdata_i = 16'h0000;
        repeat (5) @(negedge core_clk_i);
        rst_n_i = 1'b1;
        t_reset;
        t_transp;
        t_off;
        t_cmd;
        t_link;
        t_buffer;
        t_monitor;
        tally_and_finish;
    end
endmodule // tb_top
